/* tsi_far_end.sv */
// Far-end stream device: serial clock, frame pulse, evaluation pin, receive data
`timescale 1ns/1ps
module tsi_far_end (
   // Core clock that times the far end
   input  wire logic        clk,
   // Frame shape set by the bench
   input  wire logic [7:0]  chans,
   input  wire logic        pulse_pos,
   input  wire logic        wide,
   // Lines driven by the far end
   output      logic        ser_clk,
   output      logic        frame_sync,
   output      logic        frame_eval,
   output      logic [15:0] rx
);
   int     div  = 0;
   int     slot = 0;
   integer seed = 57587;

   initial begin
      ser_clk    = 1'b0;
      frame_sync = 1'b1;
      frame_eval = 1'b1;
      rx         = 16'h0000;
   end

   // Six core cycles a serial period keep each level three samples wide
   always @(posedge clk) begin
      div <= (div == 5) ? 0 : div + 1;
      ser_clk <= (div < 3);
      if (div == 0) begin
         slot <= (slot + 1 >= int'(chans) * 16) ? 0 : slot + 1;
         frame_sync <= (slot + 2 == int'(chans) * 16) ? pulse_pos : ~pulse_pos;
      end
      if (div == 3) begin
         // Stream 3 all ones, stream 4 all zeros: switched bytes need no bit alignment
         rx <= (16'($random(seed)) & 16'hffe7) | 16'h0008;
      end
      // Wide mode: evaluation pin carries a clock in step with the serial clock
      if (wide) begin
         frame_eval <= (div < 3);
      end else if (div == 3) begin
         frame_eval <= !(slot >= 100 && slot < 300);
      end
   end
endmodule // tsi_far_end

/* tsi_fifo.sv */
// Command FIFO in front of the connection memory
`timescale 1ns/1ps
module tsi_fifo
   import tsi_pkg::*;
#(
   parameter int W = 25,
   parameter int D = 16
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         reset_n,
   // Fill side
   input  wire logic         in_valid,
   output      logic         in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output      logic         out_valid,
   input  wire logic         out_ready,
   output      logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } tsi_fifo_s;

   tsi_fifo_s    q;
   tsi_fifo_s    d;
   logic [W-1:0] mem [D];
   logic [AW:0]  cnt;

   assign cnt       = q.wp - q.rp;
   assign in_ready  = (cnt != (AW+1)'(D));
   assign out_valid = (cnt != '0);
   assign out_data  = mem[q.rp[AW-1:0]];

   always_comb begin
      d = q;
      if (in_valid && in_ready) begin
         d.wp = q.wp + 1'b1;
      end
      if (out_valid && out_ready) begin
         d.rp = q.rp + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
      if (in_valid && in_ready) begin
         mem[q.wp[AW-1:0]] <= in_data;
      end
   end
endmodule // tsi_fifo

/* tsi_pkg.sv */
// Types shared by the stream and frame timing front end
package tsi_pkg;

   typedef enum logic [1:0] {
      TSI_R2M = 2'h0,
      TSI_R4M = 2'h1,
      TSI_R8M = 2'h2
   } tsi_rate_e;

   // One connection memory entry: enable, processor byte, delay mode, source
   typedef struct packed {
      logic        oe;
      logic        proc;
      logic        cdly;
      logic [10:0] val;
   } tsi_cm_s;

   typedef struct packed {
      logic [10:0] addr;
      tsi_cm_s     ent;
   } tsi_cmd_s;

   typedef enum logic [3:0] {
      TSI_TLR  = 4'h0, TSI_RTI  = 4'h1, TSI_SDS  = 4'h2, TSI_CDR  = 4'h3,
      TSI_SHDR = 4'h4, TSI_E1DR = 4'h5, TSI_PDR  = 4'h6, TSI_E2DR = 4'h7,
      TSI_UDR  = 4'h8, TSI_SIS  = 4'h9, TSI_CIR  = 4'ha, TSI_SHIR = 4'hb,
      TSI_E1IR = 4'hc, TSI_PIR  = 4'hd, TSI_E2IR = 4'he, TSI_UIR  = 4'hf
   } tsi_tap_e;

   typedef struct packed {
      tsi_tap_e   st;
      logic [1:0] ir;
      logic [1:0] ir_sh;
      logic       byp;
      logic       tck;
      logic       tdo;
      logic       oe_n;
   } tsi_tap_s;

   typedef struct packed {
      logic              ser;
      logic              f0;
      logic              f0h;
      logic              ev;
      logic              idle;
      logic              fmt_ok;
      logic [5:0]        run;
      logic [11:0]       cyc;
      logic              bufw;
      logic              arm;
      logic              mvld;
      logic [11:0]       meas;
      logic              busy;
      logic [10:0]       bidx;
      tsi_cm_s           bent;
      logic [15:0][3:0]  ofs;
      logic [15:0][15:0] dly;
      logic [15:0][7:0]  rxs;
      logic [15:0][7:0]  txb;
      logic [15:0]       txd;
      logic [15:0]       oe_n;
   } tsi_st_s;

endpackage

/* tsi_regs.svh */
// Constants of the stream and frame timing front end
`ifndef TSI_REGS_SVH
`define TSI_REGS_SVH

// Stream rate select codes
`define TSI_RATE_2M       2'h0
`define TSI_RATE_4M       2'h1
`define TSI_RATE_8M       2'h2

// Channels per stream per frame at each rate
`define TSI_CHN_2M        8'd32
`define TSI_CHN_4M        8'd64
`define TSI_CHN_8M        8'd128

// Serial clock periods per data bit, and bits of the half-bit slot index in a channel
`define TSI_CLK_PER_BIT   2
`define TSI_SLOT_BITS     4

// Stream, memory and buffer sizes
`define TSI_NUM_STREAMS   16
`define TSI_CM_DEPTH      2048
`define TSI_CM_LAST       11'h7ff
`define TSI_CMD_DEPTH     16

// Serial clock periods at one level before the idle frame level is trusted
`define TSI_IDLE_RUN      6'h20

// Test port instruction loaded on reset and at capture
`define TSI_IR_BYPASS     2'h3
`define TSI_IR_CAPTURE    2'h1

`endif

/* tsi_switch.sv */
// Serial stream, frame timing and switching front end
`timescale 1ns/1ps
`include "tsi_regs.svh"

//////////////////////////////////////////////////////////////////////////////
module tsi_switch
   import tsi_pkg::*;
(
   // Clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RESET_N,
   // Serial streams
   input  wire logic        SER_CLK,
   input  wire logic [15:0] SERIAL_IN_STREAMS,
   output      logic [15:0] SERIAL_OUT_STREAMS,
   output      logic [15:0] SERIAL_OUT_OE_N,
   // Frame timing
   input  wire logic        FRAME_SYNC_INPUT,
   input  wire logic        FRAME_EVAL_OR_WIDE_CLOCK,
   input  wire logic        WIDE_FRAME_SELECT,
   // Mode and calibration
   input  wire logic [1:0]  RATE_SELECT_FIELD,
   input  wire logic        OFS_WE,
   input  wire logic [3:0]  OFS_STREAM,
   input  wire logic [3:0]  OFS_VALUE,
   output      logic [11:0] MEAS_OFFSET,
   output      logic        MEAS_VALID,
   output      logic        FORMAT_POSITIVE,
   // Connection memory
   input  wire logic        CM_VALID,
   output      logic        CM_READY,
   input  wire logic [10:0] CM_ADDR,
   input  wire tsi_cm_s     CM_ENTRY,
   input  wire logic        BLK_START,
   input  wire tsi_cm_s     BLK_ENTRY,
   output      logic        CM_BUSY,
   // Test port
   input  wire logic        TCK,
   input  wire logic        TMS,
   input  wire logic        TDI,
   input  wire logic        TRST_N,
   output      logic        TDO,
   output      logic        TDO_OE_N
);
   tsi_st_s          q;
   tsi_st_s          d;
   // Switching memories sit outside the state struct: they have no reset
   tsi_cm_s          cm [`TSI_CM_DEPTH];
   logic [7:0]       dmem [2][16][128];

   logic             ser_rise;
   logic             hclk_rise;
   logic             fe_fall;
   logic             fstart;
   logic             tick;
   logic [7:0]       chans;
   logic [11:0]      cyc_max;
   logic [11:0]      ncyc;
   logic             nbuf;
   logic             dm_we;
   logic             cm_we;
   logic [10:0]      cm_wa;
   tsi_cm_s          cm_wd;
   logic             cmd_valid;
   logic             cmd_ready;
   tsi_cmd_s         cmd_in;
   tsi_cmd_s         cmd;
   logic [15:0]      rx_bit;
   logic [15:0][7:0] rd_byte;
   logic [15:0]      rd_oe;

   //////////////////////////////////////////////////////////////////////////
   // Sub-blocks

   assign cmd_in = '{addr: CM_ADDR, ent: CM_ENTRY};

   tsi_fifo #(
      .W ($bits(tsi_cmd_s)),
      .D (`TSI_CMD_DEPTH)
   ) u_cmd_fifo (
      .clk       (CORE_CLK),
      .reset_n   (RESET_N),
      .in_valid  (CM_VALID),
      .in_ready  (CM_READY),
      .in_data   (cmd_in),
      .out_valid (cmd_valid),
      .out_ready (cmd_ready),
      .out_data  (cmd)
   );

   tsi_tap u_tap (
      .clk      (CORE_CLK),
      .trst_n   (TRST_N),
      .tck      (TCK),
      .tms      (TMS),
      .tdi      (TDI),
      .tdo      (TDO),
      .tdo_oe_n (TDO_OE_N)
   );

   //////////////////////////////////////////////////////////////////////////
   // Frame timing

   // The serial clock is a sampled input; it must stay below half the core rate
   assign ser_rise  = SER_CLK & ~q.ser;
   assign hclk_rise = FRAME_EVAL_OR_WIDE_CLOCK & ~q.ev;
   assign fe_fall   = ~FRAME_EVAL_OR_WIDE_CLOCK & q.ev;

   always_comb begin
      case (RATE_SELECT_FIELD)
         TSI_R4M: chans = `TSI_CHN_4M;
         TSI_R8M: chans = `TSI_CHN_8M;
         default: chans = `TSI_CHN_2M;
      endcase
   end

   // One frame holds chans x 8 bits x 2 half-bit slots
   assign cyc_max = {chans, 4'h0} - 12'h001;

   // Wide mode: frame starts where the wide-mode clock first sees the pulse low
   assign fstart = WIDE_FRAME_SELECT
                 ? (hclk_rise & q.f0h & ~FRAME_SYNC_INPUT)
                 : (ser_rise & q.fmt_ok & (FRAME_SYNC_INPUT == q.idle)
                    & (q.f0 != q.idle));
   assign tick   = ser_rise | fstart;
   assign ncyc   = (fstart || q.cyc == cyc_max) ? 12'h000 : q.cyc + 12'h001;
   assign nbuf   = (ncyc == 12'h000) ? ~q.bufw : q.bufw;
   assign dm_we  = ser_rise & q.cyc[0] & (q.cyc[3:1] == 3'h7);

   //////////////////////////////////////////////////////////////////////////
   // Per-stream receive tap and transmit fetch

   for (genvar g = 0; g < `TSI_NUM_STREAMS; g++) begin : g_str
      tsi_cm_s    ent;
      logic [6:0] och;
      logic       bsel;

      assign rx_bit[g] = q.dly[g][q.ofs[g]];
      assign och       = ncyc[10:4];
      assign ent       = cm[{4'(g), och}];
      // Variable delay takes this frame's byte once it has been stored
      assign bsel      = (!ent.cdly && ({1'b0, ent.val[6:0]} + 8'h01) < {1'b0, och})
                       ? nbuf : ~nbuf;
      assign rd_byte[g] = !ent.oe  ? 8'h00
                        : ent.proc ? ent.val[7:0]
                        : dmem[bsel][ent.val[10:7]][ent.val[6:0]];
      assign rd_oe[g]   = ent.oe;
   end

   //////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      d         = q;
      cm_we     = 1'b0;
      cm_wa     = 11'h000;
      cm_wd     = '0;
      cmd_ready = 1'b0;
      d.ser     = SER_CLK;
      d.ev      = FRAME_EVAL_OR_WIDE_CLOCK;

      if (hclk_rise) begin
         d.f0h = FRAME_SYNC_INPUT;
      end

      // The idle frame level tells the two standard pulse polarities apart
      if (ser_rise) begin
         d.f0 = FRAME_SYNC_INPUT;
         if (FRAME_SYNC_INPUT != q.f0) begin
            d.run = 6'h00;
         end else if (q.run == `TSI_IDLE_RUN) begin
            d.idle   = FRAME_SYNC_INPUT;
            d.fmt_ok = 1'b1;
         end else begin
            d.run = q.run + 6'h01;
         end
      end

      // Free-running frame counter, realigned by each frame pulse
      if (tick) begin
         d.cyc  = ncyc;
         d.bufw = nbuf;
      end

      if (ser_rise) begin
         for (int s = 0; s < `TSI_NUM_STREAMS; s++) begin
            d.dly[s] = {q.dly[s][14:0], SERIAL_IN_STREAMS[s]};
            if (q.cyc[0]) begin
               d.rxs[s] = {q.rxs[s][6:0], rx_bit[s]};
            end
         end
      end

      if (tick) begin
         for (int s = 0; s < `TSI_NUM_STREAMS; s++) begin
            if (ncyc[3:0] == 4'h0) begin
               d.txb[s]  = rd_byte[s];
               d.oe_n[s] = ~rd_oe[s];
            end
            // A bit stays on the pin for both half-bit slots
            d.txd[s] = d.txb[s][3'h7 - ncyc[3:1]];
         end
      end

      // Offset measurement is armed once per frame
      if (fstart) begin
         d.arm = 1'b1;
      end
      if (!WIDE_FRAME_SELECT && fe_fall && q.arm) begin
         d.meas = q.cyc;
         d.mvld = 1'b1;
         d.arm  = 1'b0;
      end

      if (OFS_WE) begin
         d.ofs[OFS_STREAM] = OFS_VALUE;
      end

      // Block fill owns the memory port; queued commands wait behind it
      if (q.busy) begin
         cm_we  = 1'b1;
         cm_wa  = q.bidx;
         cm_wd  = q.bent;
         d.bidx = q.bidx + 11'h001;
         if (q.bidx == `TSI_CM_LAST) begin
            d.busy = 1'b0;
         end
      end else begin
         cmd_ready = 1'b1;
         if (cmd_valid) begin
            cm_we = 1'b1;
            cm_wa = cmd.addr;
            cm_wd = cmd.ent;
         end
         if (BLK_START) begin
            d.busy = 1'b1;
            d.bidx = 11'h000;
            d.bent = BLK_ENTRY;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Registers and memories

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         q      <= '0;
         q.oe_n <= '1;
         q.busy <= 1'b1;
      end else begin
         q <= d;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (cm_we) begin
         cm[cm_wa] <= cm_wd;
      end
      if (dm_we) begin
         for (int s = 0; s < `TSI_NUM_STREAMS; s++) begin
            dmem[q.bufw][s][q.cyc[10:4]] <= {q.rxs[s][6:0], rx_bit[s]};
         end
      end
   end

   assign SERIAL_OUT_STREAMS = q.txd;
   assign SERIAL_OUT_OE_N    = q.oe_n;
   assign MEAS_OFFSET        = q.meas;
   assign MEAS_VALID         = q.mvld;
   assign FORMAT_POSITIVE    = ~q.idle;
   assign CM_BUSY            = q.busy;

   //////////////////////////////////////////////////////////////////////////
   // Checks

   AST_RESET_FLOATS: assert property (@(posedge CORE_CLK)
      !RESET_N |=> (&SERIAL_OUT_OE_N && CM_BUSY && !MEAS_VALID))
      else $error("reset left outputs driven");
   AST_FRAME_WRAP: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      q.cyc <= cyc_max || $changed(RATE_SELECT_FIELD) || $past(!RESET_N))
      else $error("frame counter ran past the frame length");
   AST_BIT_TWO_SLOTS: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      $changed(SERIAL_OUT_STREAMS) |-> q.cyc[0] == 1'b0)
      else $error("output bit changed inside a bit");
   AST_WIDE_ALIGN: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      WIDE_FRAME_SELECT && fstart |-> !FRAME_SYNC_INPUT && hclk_rise ##1 q.cyc == 12'h000)
      else $error("wide frame not aligned to the low pulse");
   AST_STD_DETECT: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      !WIDE_FRAME_SELECT && fstart |-> q.fmt_ok && FRAME_SYNC_INPUT == q.idle)
      else $error("standard frame start without a learned idle level");
   AST_MEASURE: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      !WIDE_FRAME_SELECT && fe_fall && q.arm |=> MEAS_VALID && MEAS_OFFSET == $past(q.cyc))
      else $error("frame offset not captured");
   AST_HIZ_CHANNEL: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      tick && ncyc[3:0] == 4'h0 && !rd_oe[0] |=> SERIAL_OUT_OE_N[0] && !SERIAL_OUT_STREAMS[0])
      else $error("disabled channel still driven");
   AST_PROC_BYTE: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      tick && ncyc[3:0] == 4'h0 && g_str[0].ent.oe && g_str[0].ent.proc
      |=> q.txb[0] == $past(g_str[0].ent.val[7:0]))
      else $error("processor byte not loaded");
   AST_BLOCK_FILL: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      CM_BUSY && q.bidx == `TSI_CM_LAST |=> !CM_BUSY ##1 !q.busy || cmd_ready)
      else $error("block fill did not end after the last entry");
   AST_BLOCK_START: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
      BLK_START && !CM_BUSY |=> CM_BUSY && q.bidx == 11'h000 && !cmd_ready)
      else $error("block fill did not start");
endmodule // tsi_switch

/* tsi_switch_tb.sv */
// Self-checking bench of the stream and frame timing front end
`timescale 1ns/1ps
module tsi_switch_tb;
   import tsi_pkg::*;
   logic        CORE_CLK, RESET_N, SER_CLK, FRAME_SYNC_INPUT, FRAME_EVAL_OR_WIDE_CLOCK;
   logic        WIDE_FRAME_SELECT, OFS_WE, MEAS_VALID, FORMAT_POSITIVE;
   logic        CM_VALID, CM_READY, BLK_START, CM_BUSY;
   logic        TCK, TMS, TDI, TRST_N, TDO, TDO_OE_N, pol;
   logic [15:0] SERIAL_IN_STREAMS, SERIAL_OUT_STREAMS, SERIAL_OUT_OE_N;
   logic [1:0]  RATE_SELECT_FIELD;
   logic [3:0]  OFS_STREAM, OFS_VALUE;
   logic [11:0] MEAS_OFFSET;
   logic [10:0] CM_ADDR;
   logic [7:0]  chans;
   tsi_cm_s     CM_ENTRY, BLK_ENTRY;
   int          num_errors = 0;
   int          num_checks = 0;
   integer      seed = 57587;

   tsi_switch i_dut (.CORE_CLK, .RESET_N, .SER_CLK, .SERIAL_IN_STREAMS, .SERIAL_OUT_STREAMS,
      .SERIAL_OUT_OE_N, .FRAME_SYNC_INPUT, .FRAME_EVAL_OR_WIDE_CLOCK, .WIDE_FRAME_SELECT,
      .RATE_SELECT_FIELD, .OFS_WE, .OFS_STREAM, .OFS_VALUE, .MEAS_OFFSET, .MEAS_VALID,
      .FORMAT_POSITIVE, .CM_VALID, .CM_READY, .CM_ADDR, .CM_ENTRY, .BLK_START, .BLK_ENTRY,
      .CM_BUSY, .TCK, .TMS, .TDI, .TRST_N, .TDO, .TDO_OE_N);

   tsi_far_end i_far (.clk(CORE_CLK), .chans(chans), .pulse_pos(pol),
      .wide(WIDE_FRAME_SELECT), .ser_clk(SER_CLK),
      .frame_sync(FRAME_SYNC_INPUT), .frame_eval(FRAME_EVAL_OR_WIDE_CLOCK),
      .rx(SERIAL_IN_STREAMS));

   initial begin
      CORE_CLK = 1'b0;
      forever #10 CORE_CLK = ~CORE_CLK;
   end

   //////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop;
      if (num_errors == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic do_reset;
      @(negedge CORE_CLK);
      RESET_N = 1'b0;
      repeat (4) @(negedge CORE_CLK);
      chk(SERIAL_OUT_OE_N, 16'hffff);
      chk({MEAS_VALID, CM_BUSY}, 2'h1);
      RESET_N = 1'b1;
   endtask

   // Request held until the edge that sees ready high
   task automatic push(input logic [10:0] a, input tsi_cm_s e);
      int t;
      t = 0;
      @(negedge CORE_CLK);
      CM_VALID = 1'b1;
      CM_ADDR = a;
      CM_ENTRY = e;
      while (CM_READY !== 1'b1 && t < 5000) begin
         @(negedge CORE_CLK);
         t++;
      end
      @(negedge CORE_CLK);
      CM_VALID = 1'b0;
   endtask

   // Waits for a fresh enable fall, then samples mid-bit, two serial periods a bit
   task automatic rd_byte(input int i, output logic [7:0] v, output int t);
      bit seen;
      seen = 0;
      t = 0;
      while ((SERIAL_OUT_OE_N[i] !== 1'b0 || !seen) && t < 50000) begin
         seen |= (SERIAL_OUT_OE_N[i] === 1'b1);
         @(negedge CORE_CLK);
         t++;
      end
      repeat (6) @(negedge CORE_CLK);
      for (int b = 7; b >= 0; b--) begin
         v[b] = SERIAL_OUT_STREAMS[i];
         repeat (12) @(negedge CORE_CLK);
      end
   endtask

   task automatic tck(input logic ms, input logic di);
      @(negedge CORE_CLK);
      TMS = ms;
      TDI = di;
      repeat (2) @(negedge CORE_CLK);
      TCK = 1'b1;
      repeat (4) @(negedge CORE_CLK);
      TCK = 1'b0;
      repeat (4) @(negedge CORE_CLK);
   endtask

   //////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] b, v;
      int         t;
      RESET_N = 1'b0;
      WIDE_FRAME_SELECT = 1'b0;
      {OFS_WE, OFS_STREAM, OFS_VALUE, RATE_SELECT_FIELD} = '0;
      {CM_VALID, CM_ADDR, BLK_START} = '0;
      CM_ENTRY = '0;
      BLK_ENTRY = '0;
      {TCK, TMS, TDI, TRST_N} = 4'h6;
      chans = 8'd32;
      pol = 1'b0;
      repeat (2) @(negedge CORE_CLK);
      chk({TDO_OE_N, TDO}, 2'h2);
      TRST_N = 1'b1;
      tck(1'b0, 1'b0);
      tck(1'b1, 1'b0);
      tck(1'b0, 1'b0);
      tck(1'b0, 1'b0);
      repeat (6) begin
         b = 8'($random(seed));
         tck(1'b0, b[0]);
         chk({TDO_OE_N, TDO}, {1'b0, b[0]});
      end
      repeat (5) tck(1'b1, 1'b1);
      chk(TDO_OE_N, 1'b1);
      // Code 3 runs as the lowest rate; the last pass runs the wide pulse mode
      for (int r = 0; r < 5; r++) begin
         RATE_SELECT_FIELD = 2'(r);
         chans = (r == 1) ? 8'd64 : (r == 2) ? 8'd128 : 8'd32;
         pol = r[0];
         WIDE_FRAME_SELECT = (r == 4);
         do_reset;
         @(negedge CORE_CLK);
         OFS_WE = 1'b1;
         {OFS_STREAM, OFS_VALUE} = 8'($random(seed));
         @(negedge CORE_CLK);
         OFS_WE = 1'b0;
         repeat (16) push({1'b1, 10'($random(seed))}, tsi_cm_s'(14'($random(seed))));
         chk(CM_READY, 1'b0);
         b = 8'($random(seed));
         push({4'h0, 7'h01}, tsi_cm_s'({3'h6, 3'h0, b}));
         push({4'h1, 7'h05}, tsi_cm_s'({2'h2, 1'(r), 4'h3, 7'(8'($random(seed)) % chans)}));
         rd_byte(0, v, t);
         chk(v, b);
         rd_byte(0, v, t);
         chk(t + 102, chans * 96);
         rd_byte(1, v, t);
         chk(v, 8'hff);
         chk({FORMAT_POSITIVE, MEAS_VALID}, {pol, ~WIDE_FRAME_SELECT});
         // The far end drops its evaluation pin 100 slots after each frame start
         if (!WIDE_FRAME_SELECT) chk(MEAS_OFFSET, 12'h064);
      end
      @(negedge CORE_CLK);
      BLK_START = 1'b1;
      @(negedge CORE_CLK);
      BLK_START = 1'b0;
      t = 0;
      while (CM_BUSY === 1'b1 && t < 5000) begin
         @(negedge CORE_CLK);
         t++;
      end
      chk(t, 2048);
      t = 0;
      repeat (3200) begin
         @(negedge CORE_CLK);
         t += int'(SERIAL_OUT_OE_N[1:0] !== 2'h3);
      end
      chk(t, 0);
      report_and_stop;
   end

   // Whole sequence needs at most about 74000 cycles
   initial begin
      repeat (150000) @(posedge CORE_CLK);
      num_errors++;
      report_and_stop;
   end
endmodule // tsi_switch_tb

/* tsi_tap.sv */
// Test access port controller with bypass path
`timescale 1ns/1ps
module tsi_tap
   import tsi_pkg::*;
(
   // Core clock, test reset
   input  wire logic clk,
   input  wire logic trst_n,
   // Test pins
   input  wire logic tck,
   input  wire logic tms,
   input  wire logic tdi,
   output      logic tdo,
   output      logic tdo_oe_n
);
   tsi_tap_s q;
   tsi_tap_s d;
   tsi_tap_e nst;
   logic     rise;
   logic     fall;

   assign rise     = tck & ~q.tck;
   assign fall     = ~tck & q.tck;
   assign tdo      = q.tdo;
   assign tdo_oe_n = q.oe_n;

   // Pad pull-ups make an open test input read as one before it gets here
   always_comb begin
      case (q.st)
         TSI_TLR:  nst = tms ? TSI_TLR  : TSI_RTI;
         TSI_RTI:  nst = tms ? TSI_SDS  : TSI_RTI;
         TSI_SDS:  nst = tms ? TSI_SIS  : TSI_CDR;
         TSI_CDR:  nst = tms ? TSI_E1DR : TSI_SHDR;
         TSI_SHDR: nst = tms ? TSI_E1DR : TSI_SHDR;
         TSI_E1DR: nst = tms ? TSI_UDR  : TSI_PDR;
         TSI_PDR:  nst = tms ? TSI_E2DR : TSI_PDR;
         TSI_E2DR: nst = tms ? TSI_UDR  : TSI_SHDR;
         TSI_SIS:  nst = tms ? TSI_TLR  : TSI_CIR;
         TSI_CIR:  nst = tms ? TSI_E1IR : TSI_SHIR;
         TSI_SHIR: nst = tms ? TSI_E1IR : TSI_SHIR;
         TSI_E1IR: nst = tms ? TSI_UIR  : TSI_PIR;
         TSI_PIR:  nst = tms ? TSI_E2IR : TSI_PIR;
         TSI_E2IR: nst = tms ? TSI_UIR  : TSI_SHIR;
         default:  nst = tms ? TSI_SDS  : TSI_RTI;
      endcase
   end

   always_comb begin
      d     = q;
      d.tck = tck;
      if (rise) begin
         d.st = nst;
         case (q.st)
            TSI_TLR:  d.ir    = `TSI_IR_BYPASS;
            TSI_CDR:  d.byp   = 1'b0;
            TSI_SHDR: d.byp   = tdi;
            TSI_CIR:  d.ir_sh = `TSI_IR_CAPTURE;
            TSI_SHIR: d.ir_sh = {tdi, q.ir_sh[1]};
            TSI_UIR:  d.ir    = q.ir_sh;
            default:  d.byp   = q.byp;
         endcase
      end
      if (fall) begin
         d.tdo  = (q.st == TSI_SHIR) ? q.ir_sh[0] : q.byp;
         d.oe_n = !(q.st == TSI_SHDR || q.st == TSI_SHIR);
      end
   end

   // Test reset is the only asynchronous path in the block
   always_ff @(posedge clk or negedge trst_n) begin
      if (!trst_n) begin
         q      <= '0;
         q.oe_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   AST_TRST_HOLDS_RESET: assert property (@(posedge clk) !trst_n |-> q.st == TSI_TLR)
      else $error("test reset did not hold the logic-reset state");
   AST_TDO_FALL_ONLY: assert property (@(posedge clk) disable iff (!trst_n)
      $changed(tdo) |-> $past(fall))
      else $error("test data out moved away from a falling test clock");
   AST_TDO_FLOATS: assert property (@(posedge clk) disable iff (!trst_n)
      (q.st != TSI_SHDR && q.st != TSI_SHIR) ##1 fall |=> tdo_oe_n)
      else $error("test data out driven outside a scan");
endmodule // tsi_tap
